/* src/idp_device.sv */
// identifier access port: fixed identifier, fabric shift port and jtag readout
// assumes load/shift/din and the jtag pins are synchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none
`include "idp_regs.svh"

// Summary of operation
// - permanent identifier exactly 57 bits wide
// - top bits one then zero; rest unique
// - load high at edge loads identifier parallel
// - after load, serial output shows bit 56
// - load and shift together: load wins
// - shift alone: move toward output, din into bit0
// - serial output always reflects register bit 56
// - neither load nor shift: contents held except on a jtag capture or shift
// - partner raises shift already in the load cycle
// - partner may loop output back, 57-bit period
// - enable instruction must precede identifier read
// - entering shift-dr drives bit 56 onto tdo
// - staying in shift-dr shifts remaining bits out
// - jtag readout includes fabric shifted-in values
// - partner issues disable instruction after readout
module idp_device #(
  parameter int ID_W = `IDP_ID_W,
  // per-device unique part; the default value is arbitrary
  parameter logic [`IDP_ID_W-`IDP_ID_TOP_W-1:0] ID_UNIQUE = 55'h2A_5C3B_71E0_94D6,
  parameter int IR_W = `IDP_IR_W
) (
  input wire logic ref_clk,
  input wire logic rstn,
  idp_if.dev port,
  output logic cfg_enabled,
  output logic jtag_id_active
);

  if (ID_W != `IDP_ID_W || IR_W != `IDP_IR_W) begin : g_bad_width
    $error("idp_device: identifier and instruction widths are fixed");
  end

  // identifier: fixed top pattern over the unique field
  localparam logic [ID_W-1:0] ID_VALUE = {`IDP_ID_TOP, ID_UNIQUE};

  idp_pkg::idp_tap_t tap_ff;
  idp_pkg::idp_tap_t tap_step;
  idp_pkg::idp_tap_t nxt_tap;

  logic tck_q_ff;
  logic [IR_W-1:0] ir_sr_ff;
  logic [IR_W-1:0] nxt_ir_sr;
  logic [IR_W-1:0] ir_ff;
  logic [IR_W-1:0] nxt_ir;
  logic cfg_en_ff;
  logic nxt_cfg_en;
  logic bypass_ff;
  logic nxt_bypass;
  logic [ID_W-1:0] sr_ff;
  logic [ID_W-1:0] nxt_sr;
  logic loaded_ff;
  logic tdo_ff;
  logic nxt_tdo;
  logic tdo_oe_ff;
  logic nxt_tdo_oe;

  // jtag clock edge seen in the ref_clk domain
  wire tck_rise = port.tck && !tck_q_ff;

  wire in_tlr = (tap_ff == idp_pkg::TAP_RESET);
  wire in_cap_dr = (tap_ff == idp_pkg::TAP_CAP_DR);
  wire in_sh_dr = (tap_ff == idp_pkg::TAP_SH_DR);
  wire in_cap_ir = (tap_ff == idp_pkg::TAP_CAP_IR);
  wire in_sh_ir = (tap_ff == idp_pkg::TAP_SH_IR);
  wire in_upd_ir = (tap_ff == idp_pkg::TAP_UPD_IR);

  // the read instruction only reaches the register once enabled
  wire id_sel = (ir_ff == `IDP_INSTR_ID_RD) && cfg_en_ff;

  // fabric port decode: load overrides shift
  wire fab_load = port.load;
  wire fab_shift = port.shift && !port.load;

  // jtag only moves the register when fabric leaves it alone; a fabric
  // access in the same cycle wins and the jtag bit is not shifted
  wire jtag_busy_free = !port.load && !port.shift;
  wire jtag_cap = tck_rise && in_cap_dr && id_sel && !loaded_ff && jtag_busy_free;
  wire jtag_shift = tck_rise && in_sh_dr && id_sel && jtag_busy_free;

  // tap state walk
  always_comb begin
    case (tap_ff)
      idp_pkg::TAP_RESET:  tap_step = port.tms ? idp_pkg::TAP_RESET  : idp_pkg::TAP_IDLE;
      idp_pkg::TAP_IDLE:   tap_step = port.tms ? idp_pkg::TAP_SEL_DR : idp_pkg::TAP_IDLE;
      idp_pkg::TAP_SEL_DR: tap_step = port.tms ? idp_pkg::TAP_SEL_IR : idp_pkg::TAP_CAP_DR;
      idp_pkg::TAP_CAP_DR: tap_step = port.tms ? idp_pkg::TAP_EX1_DR : idp_pkg::TAP_SH_DR;
      idp_pkg::TAP_SH_DR:  tap_step = port.tms ? idp_pkg::TAP_EX1_DR : idp_pkg::TAP_SH_DR;
      idp_pkg::TAP_EX1_DR: tap_step = port.tms ? idp_pkg::TAP_UPD_DR : idp_pkg::TAP_PAU_DR;
      idp_pkg::TAP_PAU_DR: tap_step = port.tms ? idp_pkg::TAP_EX2_DR : idp_pkg::TAP_PAU_DR;
      idp_pkg::TAP_EX2_DR: tap_step = port.tms ? idp_pkg::TAP_UPD_DR : idp_pkg::TAP_SH_DR;
      idp_pkg::TAP_UPD_DR: tap_step = port.tms ? idp_pkg::TAP_SEL_DR : idp_pkg::TAP_IDLE;
      idp_pkg::TAP_SEL_IR: tap_step = port.tms ? idp_pkg::TAP_RESET  : idp_pkg::TAP_CAP_IR;
      idp_pkg::TAP_CAP_IR: tap_step = port.tms ? idp_pkg::TAP_EX1_IR : idp_pkg::TAP_SH_IR;
      idp_pkg::TAP_SH_IR:  tap_step = port.tms ? idp_pkg::TAP_EX1_IR : idp_pkg::TAP_SH_IR;
      idp_pkg::TAP_EX1_IR: tap_step = port.tms ? idp_pkg::TAP_UPD_IR : idp_pkg::TAP_PAU_IR;
      idp_pkg::TAP_PAU_IR: tap_step = port.tms ? idp_pkg::TAP_EX2_IR : idp_pkg::TAP_PAU_IR;
      idp_pkg::TAP_EX2_IR: tap_step = port.tms ? idp_pkg::TAP_UPD_IR : idp_pkg::TAP_SH_IR;
      idp_pkg::TAP_UPD_IR: tap_step = port.tms ? idp_pkg::TAP_SEL_DR : idp_pkg::TAP_IDLE;
      default:             tap_step = idp_pkg::TAP_RESET;
    endcase
  end

  assign nxt_tap = tck_rise ? tap_step : tap_ff;

  // instruction register, capture pattern in the low bits
  always_comb begin
    nxt_ir_sr = ir_sr_ff;
    nxt_ir = ir_ff;
    nxt_cfg_en = cfg_en_ff;
    if (in_tlr) begin
      nxt_ir = `IDP_INSTR_BYPASS;
      nxt_cfg_en = 1'b0;
    end else if (tck_rise && in_cap_ir) begin
      nxt_ir_sr = `IDP_IR_CAPTURE;
    end else if (tck_rise && in_sh_ir) begin
      nxt_ir_sr = {port.tdi, ir_sr_ff[IR_W-1:1]};
    end else if (tck_rise && in_upd_ir) begin
      nxt_ir = ir_sr_ff;
      // enable and disable gate the identifier readout
      if (ir_sr_ff == `IDP_INSTR_CFG_EN) begin
        nxt_cfg_en = 1'b1;
      end else if (ir_sr_ff == `IDP_INSTR_CFG_DIS) begin
        nxt_cfg_en = 1'b0;
      end
    end
  end

  // bypass cell for every other instruction
  assign nxt_bypass = (tck_rise && in_cap_dr) ? 1'b0 :
                      (tck_rise && in_sh_dr) ? port.tdi : bypass_ff;

  // identifier shift register; fabric and jtag share it
  always_comb begin
    if (fab_load || jtag_cap) begin
      nxt_sr = ID_VALUE;
    end else if (fab_shift || jtag_shift) begin
      nxt_sr = {sr_ff[ID_W-2:0], port.din};
    end else begin
      nxt_sr = sr_ff;
    end
  end

  // tdo: register top bit during shift-dr once the read is selected
  always_comb begin
    nxt_tdo = 1'b0;
    nxt_tdo_oe = 1'b0;
    if (in_sh_ir) begin
      nxt_tdo = ir_sr_ff[0];
      nxt_tdo_oe = 1'b1;
    end else if (in_sh_dr) begin
      nxt_tdo = id_sel ? sr_ff[ID_W-1] : bypass_ff;
      nxt_tdo_oe = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tap_ff <= idp_pkg::TAP_RESET;
      tck_q_ff <= 1'b0;
      ir_sr_ff <= `IDP_IR_CAPTURE;
      ir_ff <= `IDP_INSTR_BYPASS;
      cfg_en_ff <= 1'b0;
      bypass_ff <= 1'b0;
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end else begin
      tap_ff <= nxt_tap;
      tck_q_ff <= port.tck;
      ir_sr_ff <= nxt_ir_sr;
      ir_ff <= nxt_ir;
      cfg_en_ff <= nxt_cfg_en;
      bypass_ff <= nxt_bypass;
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= nxt_tdo_oe;
    end
  end

  // loaded_ff remembers a load so a jtag capture never wipes fabric
  // data shifted in after it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sr_ff <= '0;
      loaded_ff <= 1'b0;
    end else begin
      sr_ff <= nxt_sr;
      loaded_ff <= loaded_ff || fab_load || jtag_cap;
    end
  end

  // serial output is the register's top bit, a flop
  assign port.dout = sr_ff[ID_W-1];
  assign port.tdo = tdo_ff;
  assign port.tdo_oe = tdo_oe_ff;
  assign cfg_enabled = cfg_en_ff;
  assign jtag_id_active = id_sel && in_sh_dr;

endmodule
`default_nettype wire

/* src/idp_regs.svh */
// constants of the identifier access port: identifier layout, jtag codes, link timing
// assumes nothing; definitions only, included by its bare name
`ifndef IDP_REGS_SVH
`define IDP_REGS_SVH

// identifier layout
`define IDP_ID_W 57
`define IDP_ID_TOP_W 2
`define IDP_ID_TOP 2'h2

// jtag instruction register; opcode values are arbitrary
`define IDP_IR_W 6
`define IDP_IR_CAPTURE 6'h01
`define IDP_INSTR_CFG_EN 6'h10
`define IDP_INSTR_ID_RD 6'h32
`define IDP_INSTR_CFG_DIS 6'h16
`define IDP_INSTR_BYPASS 6'h3F

// jtag clock made by the partner end
`define IDP_CLK_PERIOD_NS 50
`define IDP_TCK_PERIOD_NS 200
`define IDP_TCK_HALF (`IDP_TCK_PERIOD_NS / 2 / `IDP_CLK_PERIOD_NS)

// walk to the shift states from run-test/idle, one settling step included
`define IDP_PRE_IR 5
`define IDP_PRE_DR 4
`define IDP_POST 2

`endif

/* src/idp_pkg.sv */
// types shared by both ends of the identifier access port
// assumes idp_regs.svh holds the numeric constants
package idp_pkg;

  typedef enum logic [15:0] {
    TAP_RESET  = 16'h0001,
    TAP_IDLE   = 16'h0002,
    TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008,
    TAP_SH_DR  = 16'h0010,
    TAP_EX1_DR = 16'h0020,
    TAP_PAU_DR = 16'h0040,
    TAP_EX2_DR = 16'h0080,
    TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200,
    TAP_CAP_IR = 16'h0400,
    TAP_SH_IR  = 16'h0800,
    TAP_EX1_IR = 16'h1000,
    TAP_PAU_IR = 16'h2000,
    TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } idp_tap_t;

  typedef enum logic [4:0] {
    USR_IDLE  = 5'h01,
    USR_LOAD  = 5'h02,
    USR_SHIFT = 5'h04,
    USR_SCAN  = 5'h08,
    USR_PUSH  = 5'h10
  } idp_usr_t;

endpackage

/* src/idp_if.sv */
// link between the identifier access port and its partner
// assumes one clock for both ends; tdo is pulled high when nobody drives it
`timescale 1ns/1ns
`default_nettype none
interface idp_if;
  logic load;
  logic shift;
  logic din;
  logic dout;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic tdo_line;

  assign tdo_line = tdo_oe ? tdo : 1'b1;

  modport dev (
    input load,
    input shift,
    input din,
    output dout,
    input tck,
    input tms,
    input tdi,
    output tdo,
    output tdo_oe
  );

  modport usr (
    output load,
    output shift,
    output din,
    input dout,
    output tck,
    output tms,
    output tdi,
    input tdo_line
  );
endinterface
`default_nettype wire

/* src/idp_buf.sv */
// small fifo between the identifier reader and its consumer
// assumes a single clock; depth is a power of two so pointers wrap freely
`timescale 1ns/1ns
`default_nettype none
module idp_buf #(
  parameter int W = 57,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_bad_size
    $error("idp_buf: depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;
  wire full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  wire empty = (wr_ptr_ff == rd_ptr_ff);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;

  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem_ff[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
      rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
    end
  end

  // storage holds no reset: only entries between the pointers are ever read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

/* src/idp_user.sv */
// partner end: reads the identifier by the fabric port or by a jtag walk
// assumes the device end on the far side of idp_if and one shared clock
`timescale 1ns/1ns
`default_nettype none
`include "idp_regs.svh"
module idp_user #(
  parameter int ID_W = `IDP_ID_W,
  parameter int IR_W = `IDP_IR_W,
  parameter bit LOOPBACK = 1'b0,
  parameter int BUF_DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rstn,
  idp_if.usr port,
  input wire logic fab_req,
  input wire logic jtag_req,
  output logic busy,
  output logic id_valid,
  input wire logic id_ready,
  output logic [ID_W-1:0] id_data
);
  localparam int HALF = `IDP_TCK_HALF;
  localparam int STEP_W = $clog2(`IDP_PRE_IR + ID_W + `IDP_POST + 1);

  if (HALF < 1 || ID_W != `IDP_ID_W || IR_W != `IDP_IR_W) begin : g_bad_cfg
    $error("idp_user: jtag clock too fast or widths changed");
  end

  idp_pkg::idp_usr_t st_ff;
  logic [5:0] cnt_ff;
  logic [ID_W-1:0] word_ff;
  logic [1:0] ix_ff;
  logic [STEP_W-1:0] step_ff;
  logic [$clog2(2*HALF)-1:0] ph_ff;
  logic tms_ff;
  logic tdi_ff;

  wire scan_ir = (ix_ff != 2'h2);
  wire [31:0] pre = scan_ir ? `IDP_PRE_IR : `IDP_PRE_DR;
  wire [31:0] len = scan_ir ? IR_W : ID_W;
  wire [31:0] s = 32'(step_ff);
  wire [IR_W-1:0] instr = (ix_ff == 2'h0) ? `IDP_INSTR_CFG_EN :
                          (ix_ff == 2'h1) ? `IDP_INSTR_ID_RD : `IDP_INSTR_CFG_DIS;
  wire ph_rise = (32'(ph_ff) == HALF - 1);
  wire ph_end = (32'(ph_ff) == 2 * HALF - 1);
  wire scan_last = ph_end && (s == pre + len + `IDP_POST - 1);
  wire buf_ready;

  // tms for walk step n: settle, walk in, shift, exit, update, idle
  function automatic logic tms_at(input logic [31:0] n, input logic [31:0] p,
                                  input logic [31:0] l, input logic ir);
    if (n == 0) begin
      tms_at = 1'b0;
    end else if (n < p) begin
      tms_at = ir ? (n <= 2) : (n == 1);
    end else if (n < p + l - 1) begin
      tms_at = 1'b0;
    end else begin
      tms_at = (n <= p + l);
    end
  endfunction

  wire [31:0] s_nxt = scan_last ? 32'h0 : s + 1;
  wire [31:0] bit_ix = s_nxt - pre;
  wire tdi_nxt = scan_ir && (s_nxt >= pre) && (bit_ix < len) && instr[bit_ix[2:0]];

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= idp_pkg::USR_IDLE;
      cnt_ff <= '0;
      word_ff <= '0;
      ix_ff <= '0;
      step_ff <= '0;
      ph_ff <= '0;
      tms_ff <= 1'b0;
      tdi_ff <= 1'b0;
    end else begin
      case (st_ff)
        idp_pkg::USR_IDLE: begin
          if (jtag_req) begin
            st_ff <= idp_pkg::USR_SCAN;
            ix_ff <= '0;
          end else if (fab_req) begin
            st_ff <= idp_pkg::USR_LOAD;
          end
        end
        idp_pkg::USR_LOAD: begin
          st_ff <= idp_pkg::USR_SHIFT;
          cnt_ff <= '0;
        end
        idp_pkg::USR_SHIFT: begin
          word_ff <= {word_ff[ID_W-2:0], port.dout};
          cnt_ff <= cnt_ff + 6'h01;
          if (32'(cnt_ff) == ID_W - 1) begin
            st_ff <= idp_pkg::USR_PUSH;
          end
        end
        idp_pkg::USR_SCAN: begin
          ph_ff <= ph_end ? '0 : ph_ff + 1'b1;
          if (ph_rise && !scan_ir && s >= pre && s < pre + len) begin
            word_ff <= {word_ff[ID_W-2:0], port.tdo_line};
          end
          // tms/tdi change only as tck falls
          if (ph_end) begin
            step_ff <= STEP_W'(s_nxt);
            tms_ff <= tms_at(s_nxt, pre, len, scan_ir);
            tdi_ff <= tdi_nxt;
          end
          // enable, read, shift out, then disable
          if (scan_last) begin
            ix_ff <= ix_ff + 2'h1;
            if (ix_ff == 2'h3) begin
              st_ff <= idp_pkg::USR_PUSH;
            end
          end
        end
        idp_pkg::USR_PUSH: begin
          if (buf_ready) begin
            st_ff <= idp_pkg::USR_IDLE;
          end
        end
        default: st_ff <= idp_pkg::USR_IDLE;
      endcase
    end
  end

  assign port.load = (st_ff == idp_pkg::USR_LOAD);
  // shift already rises with load, which the port must ignore
  // it stays low while the last bit is sampled so it is not lost
  assign port.shift = (st_ff == idp_pkg::USR_LOAD) ||
                      ((st_ff == idp_pkg::USR_SHIFT) && (32'(cnt_ff) < ID_W - 1));
  // loopback makes the stream repeat every identifier length
  assign port.din = LOOPBACK ? port.dout : 1'b0;
  assign port.tck = (st_ff == idp_pkg::USR_SCAN) && (32'(ph_ff) >= HALF);
  assign port.tms = tms_ff;
  assign port.tdi = tdi_ff;
  assign busy = (st_ff != idp_pkg::USR_IDLE);

  idp_buf #(
    .W(ID_W),
    .DEPTH(BUF_DEPTH)
  ) idp_buf_i (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .in_valid(st_ff == idp_pkg::USR_PUSH),
    .in_ready(buf_ready),
    .in_data(word_ff),
    .out_valid(id_valid),
    .out_ready(id_ready),
    .out_data(id_data)
  );
endmodule
`default_nettype wire

/* dv/idp_link_assertions.sv */
// checker for the link between the identifier port and its reader
// assumes one clock; instantiated beside the interface, no bind
`timescale 1ns/1ns
`default_nettype none
module idp_link_assertions #(
  parameter logic [56:0] ID = 57'h0
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic shift,
  input wire logic din,
  input wire logic dout,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  logic [6:0] idx_ff;
  logic trk_ff;
  logic tck_q_ff;
  logic rose_q_ff;
  logic rose_q2_ff;
  wire logic [6:0] nxt_idx;
  wire logic nxt_trk;

  // the bit index saturates so a stray shift cannot wrap it back to the top
  assign nxt_idx = load ? 7'h00 : (shift && idx_ff != 7'h38) ? idx_ff + 7'h01 : idx_ff;
  // any jtag clocking ends the fabric tracking, jtag may move the register
  assign nxt_trk = load | (trk_ff & ~tck);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      idx_ff <= 7'h00;
      trk_ff <= 1'b0;
      tck_q_ff <= 1'b0;
      rose_q_ff <= 1'b0;
      rose_q2_ff <= 1'b0;
    end else begin
      idx_ff <= nxt_idx;
      trk_ff <= nxt_trk;
      tck_q_ff <= tck;
      rose_q_ff <= tck & ~tck_q_ff;
      rose_q2_ff <= rose_q_ff;
    end
  end

  sequence load_then_shift_s;
    load ##1 (shift && !load);
  endsequence

  load_dout_a: assert property (load |=> dout)
    else $error("dout not high after load");
  seq_bits_a: assert property (trk_ff |-> dout == ID[7'h38 - idx_ff])
    else $error("serial bit out of order");
  top_zero_a: assert property (load_then_shift_s |=> !dout)
    else $error("second bit not zero");
  hold_dout_a: assert property (!load && !shift && !$rose(tck) |=> $stable(dout))
    else $error("dout moved while idle");
  load_pulse_a: assert property (load |=> !load)
    else $error("load longer than one cycle");
  shift_count_a: assert property ($fell(shift) |-> idx_ff == 7'h38)
    else $error("shift run not 56 long");
  oe_after_tck_a: assert property ($rose(tdo_oe) |-> rose_q_ff || rose_q2_ff)
    else $error("tdo enabled without tck rise");
  tdo_hold_a: assert property (tdo_oe && $past(tdo_oe) && !rose_q_ff && !rose_q2_ff
    |-> $stable(tdo))
    else $error("tdo moved between tck rises");
  jtag_low_a: assert property ($changed(tms) || $changed(tdi) |-> !tck)
    else $error("jtag input moved with tck high");
endmodule
`default_nettype wire

/* dv/test_device_identifier_shift_port.sv */
// self-checking bench: reader and identifier port joined by the link
// assumes the reader packs the first bit out as the word's msb
`timescale 1ns/1ns
`default_nettype none
`include "idp_regs.svh"
module test_device_identifier_shift_port;
  // per-device part; the value is arbitrary
  localparam logic [54:0] UNIQ = 55'h1B_3A5F_0C96_E247;
  logic ref_clk;
  logic rstn;
  logic fab_req;
  logic jtag_req;
  logic id_ready;
  logic busy;
  logic id_valid;
  logic [56:0] id_data;
  logic cfg_enabled;
  logic id_act;
  logic [56:0] loop_data;
  int act_cnt;
  logic [15:0] seed;
  logic [56:0] w;
  logic jt;
  logic prev_fab;
  int n_errors;
  int n_tests;

  idp_if idp_if_i();
  idp_device #(.ID_UNIQUE(UNIQ)) idp_device_i (.ref_clk(ref_clk), .rstn(rstn),
    .port(idp_if_i), .cfg_enabled(cfg_enabled), .jtag_id_active(id_act));
  // second pair with the output looped back, run in step with the first
  idp_if idp_if_loop_i();
  idp_device #(.ID_UNIQUE(UNIQ)) idp_device_loop_i (.ref_clk(ref_clk), .rstn(rstn),
    .port(idp_if_loop_i), .cfg_enabled(), .jtag_id_active());
  idp_user #(.LOOPBACK(1'b1)) idp_user_loop_i (.ref_clk(ref_clk), .rstn(rstn),
    .port(idp_if_loop_i), .fab_req(fab_req), .jtag_req(jtag_req), .busy(), .id_valid(),
    .id_ready(id_ready), .id_data(loop_data));
  idp_user idp_user_i (.ref_clk(ref_clk), .rstn(rstn), .port(idp_if_i), .fab_req(fab_req),
    .jtag_req(jtag_req), .busy(busy), .id_valid(id_valid), .id_ready(id_ready),
    .id_data(id_data));
  idp_link_assertions #(.ID({2'h2, UNIQ})) idp_link_assertions_i (.ref_clk(ref_clk),
    .rstn(rstn), .load(idp_if_i.load), .shift(idp_if_i.shift), .din(idp_if_i.din),
    .dout(idp_if_i.dout), .tck(idp_if_i.tck), .tms(idp_if_i.tms), .tdi(idp_if_i.tdi),
    .tdo(idp_if_i.tdo), .tdo_oe(idp_if_i.tdo_oe));

  // cycles in which the port reports a jtag readout under way
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      act_cnt <= 0;
    end else if (id_act) begin
      act_cnt <= act_cnt + 1;
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [56:0] id_word();
    return {2'h2, UNIQ};
  endfunction

  // register left behind by a fabric read: 56 shifts with din held low
  function automatic logic [56:0] drained_word(input logic [56:0] v);
    return {v[0], 56'h0};
  endfunction

  // register left behind by a looped fabric read: turned 56 places
  function automatic logic [56:0] looped_word(input logic [56:0] v);
    return {v[0], v[56:1]};
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [56:0] seen, input logic [56:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_up(input string what);
    n_errors++;
    $display("BAD %0t no answer from %s", $time, what);
    print_verdict();
  endtask

  task automatic request(input logic j);
    @(posedge ref_clk);
    fab_req <= ~j;
    jtag_req <= j;
    @(posedge ref_clk);
    fab_req <= 1'b0;
    jtag_req <= 1'b0;
  endtask

  task automatic wait_idle();
    int i;
    for (i = 0; i < 4000; i++) begin
      @(posedge ref_clk);
      #1;
      if (busy === 1'b0) break;
    end
    if (i == 4000) give_up("reader");
  endtask

  // consumer stalls for a while, then takes one word
  task automatic pop(input logic [56:0] exp, input logic [56:0] exp_loop, input int stall);
    int i;
    repeat (stall) @(posedge ref_clk);
    for (i = 0; i < 4000; i++) begin
      @(posedge ref_clk);
      #1;
      if (id_valid === 1'b1) break;
    end
    if (i == 4000) give_up("buffer");
    check(id_data, exp);
    check(loop_data, exp_loop);
    @(posedge ref_clk);
    id_ready <= 1'b1;
    @(posedge ref_clk);
    id_ready <= 1'b0;
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    rstn = 1'b0;
    fab_req = 1'b0;
    jtag_req = 1'b0;
    id_ready = 1'b0;
    n_errors = 0;
    n_tests = 0;
    seed = 16'h002E;
    w = id_word();
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    #1;
    check({55'h0, busy, id_valid}, 57'h0);
    request(1'b1);
    wait_idle();
    pop(w, w, 0);
    check({56'h0, cfg_enabled}, 57'h0);
    check(57'(act_cnt), 57'(`IDP_ID_W * 2 * `IDP_TCK_HALF));
    $display("test 1 jtag read after reset done");
    request(1'b0);
    wait_idle();
    pop(w, w, 3);
    check({56'h0, idp_if_i.dout}, {56'h0, w[0]});
    $display("test 2 fabric read done");
    request(1'b1);
    wait_idle();
    pop(drained_word(w), looped_word(w), 1);
    check(57'(act_cnt), 57'(2 * `IDP_ID_W * 2 * `IDP_TCK_HALF));
    $display("test 3 jtag after fabric done");
    request(1'b0);
    wait_idle();
    request(1'b0);
    wait_idle();
    request(1'b0);
    // third word has no room: the reader must hold it, so busy stays up
    repeat (80) @(posedge ref_clk);
    #1;
    check({56'h0, busy}, 57'h1);
    pop(w, w, 5);
    pop(w, w, 0);
    pop(w, w, 2);
    $display("test 4 full buffer done");
    // jtag only follows a fabric read, since the register it sees is then known
    prev_fab = 1'b1;
    for (int k = 0; k < 10; k++) begin
      seed = lfsr(seed);
      jt = seed[4] & prev_fab;
      repeat (seed[2:0]) @(posedge ref_clk);
      request(jt);
      wait_idle();
      seed = lfsr(seed);
      pop(jt ? drained_word(w) : w, jt ? looped_word(w) : w, seed[3:0]);
      prev_fab = ~jt;
    end
    $display("test 5 random reads done");
    print_verdict();
  end
endmodule
`default_nettype wire
